// file: hdl/csc_pkg.sv
package csc_pkg;
    localparam int CSC_NUM_SINKS = 5;
    localparam int CSC_NUM_GATE_PINS = 3;
    localparam int CSC_ADDR_W = 8;
    localparam int CSC_DATA_W = 8;

    localparam logic [7:0] CSC_ADDR_SINK1_LEVEL = 8'h24;
    localparam logic [7:0] CSC_ADDR_SINK2_LEVEL = 8'h25;
    localparam logic [7:0] CSC_ADDR_SINK3_LEVEL = 8'h26;
    localparam logic [7:0] CSC_ADDR_SINK4_LEVEL = 8'h27;
    localparam logic [7:0] CSC_ADDR_SINK1_TO_4_MODE = 8'h28;
    localparam logic [7:0] CSC_ADDR_SINK5_LEVEL = 8'h29;
    localparam logic [7:0] CSC_ADDR_SINK1_TO_4_PIN_SELECT = 8'h2a;
    localparam logic [7:0] CSC_ADDR_SINK5_MODE_AND_PIN_SELECT = 8'h19;
    localparam logic [7:0] CSC_ADDR_SINK_STATUS = 8'h2c;

    localparam logic [7:0] CSC_LEVEL_RESET = 8'h00;
    localparam logic [7:0] CSC_LEVEL_OFF = 8'h00;
    localparam logic [7:0] CSC_BYTE_RESET = 8'h00;
    localparam logic [7:0] CSC_READ_UNMAPPED = 8'h00;
    localparam logic [3:0] CSC_SINK5_CTRL_USED = 4'h0;

    localparam int CSC_FIELD_W = 2;
    localparam int CSC_SINK5_MODE_LSB = 0;
    localparam int CSC_SINK5_SEL_LSB = 2;

    typedef enum logic [1:0] {
        CSC_MODE_OFF = 2'b00,
        CSC_MODE_ACTIVE = 2'b01,
        CSC_MODE_GATED = 2'b10,
        CSC_MODE_GATED_ALT = 2'b11
    } csc_mode_t;

    typedef enum logic [1:0] {
        CSC_SEL_PIN_ONE = 2'b00,
        CSC_SEL_PIN_TWO = 2'b01,
        CSC_SEL_PIN_THREE = 2'b10,
        CSC_SEL_UNDEFINED = 2'b11
    } csc_sel_t;

    typedef struct packed {
        logic [CSC_ADDR_W-1:0] addr;
        logic [CSC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } csc_bus_req_t;

    typedef struct packed {
        logic [CSC_NUM_SINKS-1:0] drive;
        logic [CSC_NUM_SINKS-1:0][7:0] level;
    } csc_sink_out_t;
endpackage

// file: hdl/csc_current_sink_control.sv
module csc_current_sink_control
    import csc_pkg::*;
#(
    parameter int NUM_SINKS = csc_pkg::CSC_NUM_SINKS
) (
    input wire logic clk, // 200 MHz system clock
    input wire logic rst_n, // async active-low reset
    input wire csc_pkg::csc_bus_req_t bus_req, // register port request
    output logic [7:0] bus_rdata, // read data, cycle after read strobe
    input wire logic [2:0] general_pin_in, // general pins one..three levels
    output csc_pkg::csc_sink_out_t sink_out, // per-sink drive enable and level
    output logic [4:0] sink_pin_on // sink pins drawing current
);
    import csc_pkg::*;

    typedef struct packed {
        logic [3:0][7:0] level14;
        logic [7:0] level5;
        logic [7:0] mode14;
        logic [7:0] sel14;
        logic [3:0] ctrl5;
        logic [2:0] pin_meta;
        logic [2:0] pin_sync;
        logic [7:0] rdata;
        csc_sink_out_t sout;
        logic [4:0] pin_on;
    } csc_state_t;

    csc_state_t s_q;
    csc_state_t s_d;

    // level of the gating pin chosen by a selector; code 11 has no pin behind it
    function automatic logic csc_gate_level(input logic [1:0] sel, input logic [2:0] pins);
        logic level;
        level = 1'b0;
        unique case (csc_sel_t'(sel))
            CSC_SEL_PIN_ONE: begin
                level = pins[0];
            end
            CSC_SEL_PIN_TWO: begin
                level = pins[1];
            end
            CSC_SEL_PIN_THREE: begin
                level = pins[2];
            end
            CSC_SEL_UNDEFINED: begin
                level = 1'b0;
            end
        endcase
        return level;
    endfunction

    // mode decode; upper bit set means pin-gated
    function automatic logic csc_sink_on(input logic [1:0] mode, input logic [1:0] sel,
                                         input logic [2:0] pins);
        logic on;
        on = 1'b0;
        unique case (csc_mode_t'(mode))
            CSC_MODE_OFF: begin
                on = 1'b0;
            end
            CSC_MODE_ACTIVE: begin
                on = 1'b1;
            end
            CSC_MODE_GATED, CSC_MODE_GATED_ALT: begin
                on = csc_gate_level(sel, pins);
            end
        endcase
        return on;
    endfunction

    // two-bit field number idx of a shared byte
    function automatic logic [1:0] csc_field(input logic [7:0] byte_v, input int idx);
        return byte_v[idx*CSC_FIELD_W +: CSC_FIELD_W];
    endfunction

    // register writes; unmapped addresses are ignored
    function automatic csc_state_t csc_write_regs(input csc_state_t st, input csc_bus_req_t req);
        csc_state_t nx;
        nx = st;
        if (req.wr) begin
            unique case (req.addr)
                CSC_ADDR_SINK1_LEVEL: begin
                    nx.level14[0] = req.wdata;
                end
                CSC_ADDR_SINK2_LEVEL: begin
                    nx.level14[1] = req.wdata;
                end
                CSC_ADDR_SINK3_LEVEL: begin
                    nx.level14[2] = req.wdata;
                end
                CSC_ADDR_SINK4_LEVEL: begin
                    nx.level14[3] = req.wdata;
                end
                CSC_ADDR_SINK1_TO_4_MODE: begin
                    nx.mode14 = req.wdata;
                end
                CSC_ADDR_SINK5_LEVEL: begin
                    nx.level5 = req.wdata;
                end
                CSC_ADDR_SINK1_TO_4_PIN_SELECT: begin
                    nx.sel14 = req.wdata;
                end
                CSC_ADDR_SINK5_MODE_AND_PIN_SELECT: begin
                    nx.ctrl5 = req.wdata[3:0];
                end
                default: begin
                end
            endcase
        end
        return nx;
    endfunction

    // read-back multiplexer; status is read-only
    function automatic logic [7:0] csc_read_mux(input logic [7:0] addr, input csc_state_t st);
        logic [7:0] data;
        data = CSC_READ_UNMAPPED;
        unique case (addr)
            CSC_ADDR_SINK1_LEVEL: begin
                data = st.level14[0];
            end
            CSC_ADDR_SINK2_LEVEL: begin
                data = st.level14[1];
            end
            CSC_ADDR_SINK3_LEVEL: begin
                data = st.level14[2];
            end
            CSC_ADDR_SINK4_LEVEL: begin
                data = st.level14[3];
            end
            CSC_ADDR_SINK1_TO_4_MODE: begin
                data = st.mode14;
            end
            CSC_ADDR_SINK5_LEVEL: begin
                data = st.level5;
            end
            CSC_ADDR_SINK1_TO_4_PIN_SELECT: begin
                data = st.sel14;
            end
            CSC_ADDR_SINK5_MODE_AND_PIN_SELECT: begin
                data = {CSC_SINK5_CTRL_USED, st.ctrl5};
            end
            CSC_ADDR_SINK_STATUS: begin
                data = {3'b000, st.pin_on};
            end
            default: begin
                data = CSC_READ_UNMAPPED;
            end
        endcase
        return data;
    endfunction

    logic [4:0][1:0] mode_v;
    logic [4:0][1:0] sel_v;
    logic [4:0][7:0] level_v;
    logic [4:0] on_v;
    logic [4:0] lit_v;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_fields
            assign mode_v[gi] = csc_field(s_q.mode14, gi);
            assign sel_v[gi] = csc_field(s_q.sel14, gi);
            assign level_v[gi] = s_q.level14[gi];
        end
    endgenerate
    assign mode_v[4] = s_q.ctrl5[CSC_SINK5_MODE_LSB +: CSC_FIELD_W];
    assign sel_v[4] = s_q.ctrl5[CSC_SINK5_SEL_LSB +: CSC_FIELD_W];
    assign level_v[4] = s_q.level5;

    generate
        for (gi = 0; gi < CSC_NUM_SINKS; gi++) begin : g_sinks
            assign on_v[gi] = csc_sink_on(mode_v[gi], sel_v[gi], s_q.pin_sync);
            assign lit_v[gi] = on_v[gi] && (level_v[gi] != CSC_LEVEL_OFF);
        end
    endgenerate

    always_comb begin
        s_d = s_q;

        // two-flop synchroniser; only pin_sync feeds the gating logic
        s_d.pin_meta = general_pin_in;
        s_d.pin_sync = s_q.pin_meta;

        s_d = csc_write_regs(s_d, bus_req);

        // read data stands one cycle, zero otherwise
        s_d.rdata = CSC_READ_UNMAPPED;
        if (bus_req.rd) begin
            s_d.rdata = csc_read_mux(bus_req.addr, s_q);
        end

        // level code passes through; the analog side turns it into current
        for (int i = 0; i < CSC_NUM_SINKS; i++) begin
            s_d.sout.level[i] = level_v[i];
            s_d.sout.drive[i] = lit_v[i];
            s_d.pin_on[i] = lit_v[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.level14 <= {4{CSC_LEVEL_RESET}};
            s_q.level5 <= CSC_LEVEL_RESET;
            s_q.mode14 <= CSC_BYTE_RESET;
            s_q.sel14 <= CSC_BYTE_RESET;
            s_q.ctrl5 <= CSC_BYTE_RESET[3:0];
            s_q.pin_meta <= 3'b000;
            s_q.pin_sync <= 3'b000;
            s_q.rdata <= CSC_READ_UNMAPPED;
            s_q.sout <= '0;
            s_q.pin_on <= 5'b0_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata = s_q.rdata;
    assign sink_out = s_q.sout;
    assign sink_pin_on = s_q.pin_on;
endmodule // csc_current_sink_control

// file: bench/csc_assertions.sv
module csc_chk
    import csc_pkg::*;
(
    input logic clk, // clock
    input logic rst_n, // reset
    input csc_pkg::csc_bus_req_t bus_req, // bus
    input logic [7:0] bus_rdata, // data
    input logic [2:0] general_pin_in, // pins
    input csc_pkg::csc_sink_out_t sink_out, // sinks
    input logic [4:0] sink_pin_on // loads
);
    wire [7:0] wa = bus_req.wr ? bus_req.addr : 8'h00;
    wire [1:0] wm = bus_req.wdata[1:0];
    wire [4:0] dr = sink_out.drive;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    empty_off_a: assert property (dr[2] |-> sink_out.level[2] != 8'h00) else $error("empty");
    pin_drive_a: assert property (sink_pin_on == dr) else $error("pin");
    level_one_a: assert property (wa == 8'h24 |-> ##2 sink_out.level[0] == $past(bus_req.wdata, 2))
        else $error("level1");
    level_five_a: assert property (wa == 8'h29 |-> ##2 sink_out.level[4] == $past(bus_req.wdata, 2))
        else $error("level5");
    mode_off_a: assert property (wa == 8'h28 && wm == 2'b00 |-> ##2 !dr[0]) else $error("off1");
    sink5_off_a: assert property (wa == 8'h19 && wm == 2'b00 |-> ##2 !dr[4]) else $error("off5");
    drive_cause_a: assert property ($changed(dr) |-> $past(bus_req.wr, 2) ||
        $past(general_pin_in, 3) != $past(general_pin_in, 4)) else $error("cause");
    spare_bits_a: assert property (bus_req.rd && bus_req.addr == 8'h19 |=> bus_rdata[7:4] == 4'h0)
        else $error("spare");
    cover property (dr[4] && general_pin_in[2]);
    cover property (dr[1]);
    cover property (wa == 8'h19);
endmodule // csc_chk
bind csc_current_sink_control csc_chk chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .general_pin_in(general_pin_in), .sink_out(sink_out), .sink_pin_on(sink_pin_on));

// file: bench/csc_load_model.sv
module csc_load_model (
    input logic [4:0] sink_pin_on, // sink pins
    output logic [4:0] lit // loads lit
);
    assign lit = sink_pin_on;
endmodule // csc_load_model

// file: bench/csc_current_sink_control_bench.sv
module csc_current_sink_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import csc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    csc_bus_req_t req = '0;
    logic [2:0] gp = 3'h0;
    logic [7:0] rdata;
    csc_sink_out_t so;
    logic [4:0] on, lit;
    int mismatches = 0, checks = 0;
    csc_current_sink_control dut (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
        .general_pin_in(gp), .sink_out(so), .sink_pin_on(on));
    csc_load_model loads (.sink_pin_on(on), .lit(lit));
    initial forever #2.5 clk = ~clk;
    task check(string n, logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) $display("BAD %s exp %h seen %h", n, exp, seen);
        mismatches += int'(seen !== exp);
    endtask
    task wrs(logic [15:0] l [$]);
        foreach (l[i]) begin
            @(posedge clk) req <= '{l[i][15:8], l[i][7:0], 1'b1, 1'b0};
            @(posedge clk) req.wr <= 1'b0;
        end
    endtask
    task rd(logic [7:0] a, exp);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req.rd <= 1'b0;
        #1 check("read", rdata, exp);
    endtask
    task sinks(logic [4:0] exp);
        repeat (4) @(posedge clk);
        #1 check("sinks", 8'(lit), 8'(exp));
        check("drive", 8'(so.drive), 8'(exp));
    endtask
    task reset_values();
        for (logic [7:0] a = 8'h24; a < 8'h2b; a++) rd(a, 8'h00);
        rd(8'h19, 8'h00);
        rd(8'h2c, 8'h00);
    endtask
    task active();
        wrs({16'h24ff, 16'h2501, 16'h2600, 16'h2780, 16'h29ff, 16'h2855, 16'h19f1});
        check("level1", so.level[0], 8'hff);
        check("level5", so.level[4], 8'hff);
        sinks(5'h1b);
        rd(8'h2c, 8'h1b);
    endtask
    task gated();
        wrs({16'h2640, 16'h28fe, 16'h2a24, 16'h19fa});
        rd(8'h19, 8'h0a);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk) gp <= 3'(k);
            sinks({k[2], k[0], k[2], k[1:0]});
        end
    endtask
    task off();
        wrs({16'h2800, 16'h1900, 16'h3055});
        sinks(5'h00);
        rd(8'h30, 8'h00);
    endtask
    task end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        reset_values();
        active();
        gated();
        off();
        end_of_test();
    end
endmodule // csc_current_sink_control_bench
